//--- acw_pkg.sv
// ****************************************************************
// Shared constants for the word codec
// ****************************************************************
package acw_pkg;
   // Clock and line rates
   localparam int CLK_HZ = 20_000_000; // System clock
   localparam int HI_BPS = 100_000; // High speed rate
   localparam int LO_BPS = 12_500; // Low speed rate
   localparam int BIT_HI_CYC = CLK_HZ / HI_BPS; // Cycles per high speed bit
   localparam int BIT_LO_CYC = CLK_HZ / LO_BPS; // Cycles per low speed bit
   localparam logic [8:0] Q_HI_CYC = 9'(BIT_HI_CYC / 4); // Quarter bit, high
   localparam logic [8:0] Q_LO_CYC = 9'(BIT_LO_CYC / 4); // Quarter bit, low

   // Receive rate window
   localparam int RATE_TOL_PCT = 10; // Accepted deviation in percent
   localparam logic [10:0] RATE_HI_MIN = 11'(BIT_HI_CYC * (100 - RATE_TOL_PCT) / 100);
   localparam logic [10:0] RATE_HI_MAX = 11'(BIT_HI_CYC * (100 + RATE_TOL_PCT) / 100);
   localparam logic [10:0] RATE_LO_MIN = 11'(BIT_LO_CYC * (100 - RATE_TOL_PCT) / 100);
   localparam logic [10:0] RATE_LO_MAX = 11'(BIT_LO_CYC * (100 + RATE_TOL_PCT) / 100);

   // Word layout
   localparam logic [5:0] WORD_BITS = 6'h20; // Bits per word
   localparam logic [5:0] CODING_BIT = 6'h0C; // Bit spoiled by coding error
   localparam logic [5:0] BITS_SAT = 6'h3F; // Received bit count ceiling

   // Gap measurement in quarter bits
   localparam logic [7:0] BIT_Q = 8'h04; // Quarters per bit
   localparam logic [7:0] RX_END_Q = 8'h06; // Quarters since last edge ending a word
   localparam logic [7:0] GAP_MIN_Q = 8'h10; // Shortest legal gap, four bits
   localparam logic [7:0] GAP_MAX_Q = 8'hEB; // Measurement ceiling, 58.75 bits
   localparam logic [7:0] QCOUNT_RST = 8'hFF; // No word seen yet

   // Status report fields
   localparam int ST_GAP_LSB = 0; // Gap in quarter bits, 8 bits
   localparam int ST_GAP_ERR = 8; // Gap too short
   localparam int ST_CNT_ERR = 9; // Bit count not 32
   localparam int ST_COD_ERR = 10; // Coding or rate fault
   localparam int ST_PAR_ERR = 11; // Parity fault

   // Bit count injection choice
   typedef enum logic [1:0] {
      ACW_CNT_NONE = 2'h0,
      ACW_CNT_PLUS = 2'h1,
      ACW_CNT_MINUS = 2'h2
   } acw_cnt_t;

   // Transmit sequencer states
   typedef enum logic [2:0] {
      TX_IDLE = 3'b001,
      TX_BIT = 3'b010,
      TX_GAP = 3'b100
   } acw_tx_state_t;
endpackage : acw_pkg

//--- acw_quarter_timer.sv
// ****************************************************************
// Quarter bit tick generator
// ****************************************************************
module acw_quarter_timer (
   input wire logic clk,
   input wire logic srst,
   input wire logic speedHigh,
   input wire logic restart,
   output logic qTick
);
   import acw_pkg::*;

   logic [8:0] cnt; // Cycles left in this quarter
   logic [8:0] reload; // Quarter length minus one

   // Reload picks the rate
   assign reload = speedHigh ? (Q_HI_CYC - 9'h001) : (Q_LO_CYC - 9'h001);
   // Tick on the last cycle of a quarter
   assign qTick = (cnt == 9'h000) && !restart;

   // Down counter, restarted to align with a bit edge
   always_ff @(posedge clk) begin
      if (srst || restart || (cnt == 9'h000)) begin
         cnt <= srst ? 9'h000 : reload;
      end else begin
         cnt <= cnt - 9'h001;
      end
   end
endmodule : acw_quarter_timer

//--- acw_codec.sv
// Functional notes
// (RQ1) Transmit at 100 or 12.5 kbit/s
// (RQ2) Idle gap of 0 to 255 bits
// (RQ3) Transmit bit 32 is parity or data
// (RQ4) Inject gap, count, coding, parity errors
// (RQ5) Receive accepts rate within ten percent
// (RQ6) Receive bit 32 is parity or data
// (RQ7) Measure gap 0 to 58.75 bits, quarters
// (RQ8) Flag gap, count and coding errors
// (RQ9) Check parity only in parity mode
// (RQ10) Deliver word plus 16-bit status
// (RQ11) Serialise word, parity and gap bits
// (RQ12) Parity bit makes word odd
module acw_codec (
   input wire logic clk,
   input wire logic srst,
   input wire logic speedHigh,
   input wire logic [7:0] gapBits,
   input wire logic txParityMode,
   input wire logic injGap,
   input wire acw_pkg::acw_cnt_t injCount,
   input wire logic injCoding,
   input wire logic injParity,
   input wire logic [31:0] txWord,
   input wire logic txValid,
   output logic txReady,
   output logic txHi,
   output logic txLo,
   input wire logic rxParityMode,
   input wire logic rxHi,
   input wire logic rxLo,
   output logic [31:0] rxWord,
   output logic [15:0] rxStatus,
   output logic rxValid
);
   import acw_pkg::*;

   // ****************************************************************
   // Transmit side
   // ****************************************************************
   acw_tx_state_t txState; // Sequencer state
   acw_tx_state_t next_txState; // Next sequencer state
   logic [31:0] txShift; // Bits still to send, bit 1 first
   logic [5:0] bitNum; // Current bit, from 1
   logic [5:0] bitTotal; // Bits in this word
   logic [7:0] gapLeft; // Gap bits still to send
   logic [1:0] qPhase; // Quarter within the bit
   logic codingArm; // Coding error armed for this word
   logic txQTick; // Quarter tick
   logic txStart; // Word taken
   logic bitEnd; // Last quarter of a bit ends
   logic lastBit; // Current bit is the final one
   logic codingHere; // This bit is spoiled
   logic parityBit; // Generated odd parity
   logic [31:0] loadWord; // Word with bit 32 resolved
   logic [7:0] loadGap; // Gap after injection
   logic [5:0] loadTotal; // Bit count after injection
   logic pulseDrive; // Line in the pulse half of a bit

   // Start and boundary decode
   assign txReady = (txState == TX_IDLE);
   assign txStart = txReady && txValid;
   assign bitEnd = txQTick && (qPhase == 2'h3);
   assign lastBit = (bitNum == bitTotal);
   assign codingHere = codingArm && (bitNum == CODING_BIT); // RQ4
   assign pulseDrive = (txState == TX_BIT) && !qPhase[1] && !codingHere; // RQ11

   // Bit 32 as parity or data, odd parity over the word
   assign parityBit = ~^txWord[30:0]; // RQ12
   assign loadWord = txParityMode ? {parityBit ^ injParity, txWord[30:0]} : txWord; // RQ3 RQ4
   // Gap shortened by one bit when injected
   assign loadGap = (injGap && gapBits != 8'h00) ? gapBits - 8'h01 : gapBits; // RQ2 RQ4
   // One bit more or less when injected
   assign loadTotal = (injCount == ACW_CNT_PLUS) ? WORD_BITS + 6'h01 :
                      (injCount == ACW_CNT_MINUS) ? WORD_BITS - 6'h01 : WORD_BITS; // RQ4

   // Sequencer next state
   always_comb begin
      next_txState = txState;
      unique case (txState)
         TX_IDLE: begin
            if (txValid) begin
               next_txState = TX_BIT;
            end
         end
         TX_BIT: begin
            if (bitEnd && lastBit) begin
               next_txState = (gapLeft == 8'h00) ? TX_IDLE : TX_GAP; // RQ2
            end
         end
         TX_GAP: begin
            if (bitEnd && gapLeft == 8'h01) begin
               next_txState = TX_IDLE;
            end
         end
         default: begin
            next_txState = TX_IDLE;
         end
      endcase
   end

   // Quarter timer aligned to each word start
   acw_quarter_timer txTimer (
      .clk(clk),
      .srst(srst),
      .speedHigh(speedHigh), // RQ1
      .restart(txStart),
      .qTick(txQTick)
   );

   // Sequencer registers
   always_ff @(posedge clk) begin
      if (srst) begin
         txState <= TX_IDLE;
         txShift <= 32'h0000_0000;
         bitNum <= 6'h00;
         bitTotal <= WORD_BITS;
         gapLeft <= 8'h00;
         qPhase <= 2'h0;
         codingArm <= 1'b0;
      end else begin
         txState <= next_txState;
         if (txStart) begin
            txShift <= loadWord;
            bitNum <= 6'h01;
            bitTotal <= loadTotal;
            gapLeft <= loadGap;
            qPhase <= 2'h0;
            codingArm <= injCoding;
         end else if (txQTick) begin
            qPhase <= qPhase + 2'h1;
            if (bitEnd && txState == TX_BIT) begin
               // Extra bit under plus injection sends a zero
               txShift <= {1'b0, txShift[31:1]}; // RQ11
               bitNum <= bitNum + 6'h01;
            end else if (bitEnd && txState == TX_GAP) begin
               gapLeft <= gapLeft - 8'h01;
            end
         end
      end
   end

   // Line outputs, return to zero in second half
   always_ff @(posedge clk) begin
      if (srst) begin
         txHi <= 1'b0;
         txLo <= 1'b0;
      end else begin
         txHi <= pulseDrive && txShift[0]; // RQ11
         txLo <= pulseDrive && !txShift[0]; // RQ11
      end
   end

   // ****************************************************************
   // Receive side
   // ****************************************************************
   logic prevAct; // Line active last cycle
   logic lineAct; // Line carries a pulse
   logic pulseStart; // Leading edge of a bit
   logic rxQTick; // Quarter tick since last edge
   logic [7:0] qCount; // Quarters since last edge
   logic [10:0] rxCyc; // Cycles since last edge
   logic inWord; // Word being collected
   logic [31:0] rxShift; // Collected bits
   logic [5:0] rxBits; // Bits collected
   logic [7:0] rxGap; // Gap before this word
   logic rxCoding; // Coding or rate fault seen
   logic rateOk; // Edge spacing within window
   logic [7:0] gapCalc; // Gap from last bit end
   logic wordEnd; // Null long enough to close word
   logic parFail; // Parity fault
   logic [15:0] next_status; // Status being closed

   // Accepted spacing of consecutive bit edges
   function automatic logic inTol(input logic [10:0] cyc, input logic hs);
      inTol = hs ? (cyc >= RATE_HI_MIN && cyc <= RATE_HI_MAX)
                 : (cyc >= RATE_LO_MIN && cyc <= RATE_LO_MAX);
   endfunction : inTol

   assign lineAct = rxHi || rxLo;
   assign pulseStart = lineAct && !prevAct;
   assign rateOk = inTol(rxCyc, speedHigh); // RQ5
   // Gap counts from the end of the previous bit
   assign gapCalc = (qCount < BIT_Q) ? 8'h00 :
                    (qCount - BIT_Q > GAP_MAX_Q) ? GAP_MAX_Q : qCount - BIT_Q; // RQ7
   assign wordEnd = inWord && !pulseStart && (qCount >= RX_END_Q);
   assign parFail = rxParityMode && (rxBits == WORD_BITS) && !(^rxShift); // RQ9
   assign next_status = {4'h0, parFail, rxCoding, rxBits != WORD_BITS,
                         rxGap < GAP_MIN_Q, rxGap}; // RQ8 RQ10

   // Quarter timer aligned to each received edge
   acw_quarter_timer rxTimer (
      .clk(clk),
      .srst(srst),
      .speedHigh(speedHigh),
      .restart(pulseStart),
      .qTick(rxQTick)
   );

   // Edge timing counters
   always_ff @(posedge clk) begin
      if (srst) begin
         prevAct <= 1'b0;
         qCount <= QCOUNT_RST;
         rxCyc <= 11'h7FF;
      end else begin
         prevAct <= lineAct;
         if (pulseStart) begin
            qCount <= 8'h00;
            rxCyc <= 11'h001;
         end else begin
            if (rxQTick && qCount != 8'hFF) begin
               qCount <= qCount + 8'h01;
            end
            if (rxCyc != 11'h7FF) begin
               rxCyc <= rxCyc + 11'h001;
            end
         end
      end
   end

   // Word collection
   always_ff @(posedge clk) begin
      if (srst) begin
         inWord <= 1'b0;
         rxShift <= 32'h0000_0000;
         rxBits <= 6'h00;
         rxGap <= GAP_MAX_Q;
         rxCoding <= 1'b0;
      end else if (pulseStart && !inWord) begin
         // First bit opens a word and freezes the gap
         inWord <= 1'b1;
         rxShift <= {rxHi, 31'h0000_0000};
         rxBits <= 6'h01;
         rxGap <= gapCalc; // RQ7
         rxCoding <= rxHi && rxLo; // RQ8
      end else if (pulseStart) begin
         rxShift <= {rxHi, rxShift[31:1]};
         rxBits <= (rxBits == BITS_SAT) ? BITS_SAT : rxBits + 6'h01;
         rxCoding <= rxCoding || (rxHi && rxLo) || !rateOk; // RQ5 RQ8
      end else if (wordEnd) begin
         inWord <= 1'b0;
      end else if (inWord && rxHi && rxLo) begin
         rxCoding <= 1'b1; // RQ8
      end
   end

   // Word and report delivery
   always_ff @(posedge clk) begin
      if (srst) begin
         rxWord <= 32'h0000_0000;
         rxStatus <= 16'h0000;
         rxValid <= 1'b0;
      end else begin
         rxValid <= wordEnd; // RQ10
         if (wordEnd) begin
            // Bit 32 always delivered, as data or parity
            rxWord <= rxShift; // RQ6
            rxStatus <= next_status; // RQ10
         end
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   logic [10:0] hiLen; // Helper: length of current high pulse
   always_ff @(posedge clk) begin
      if (srst || !txHi) begin
         hiLen <= 11'h000;
      end else begin
         hiLen <= hiLen + 11'h001;
      end
   end

   property p_pulse_len;
      @(posedge clk) disable iff (srst)
      $fell(txHi) && $stable(speedHigh) |->
         hiLen == (speedHigh ? 11'(2 * Q_HI_CYC) : 11'(2 * Q_LO_CYC));
   endproperty
   a_pulse_len: assert property (p_pulse_len) else $error("tx pulse length wrong"); // RQ1

   property p_gap_null;
      @(posedge clk) disable iff (srst)
      (txState == TX_GAP) ##1 (txState == TX_GAP) |-> !txHi && !txLo;
   endproperty
   a_gap_null: assert property (p_gap_null) else $error("line not null in gap"); // RQ2

   property p_parity_odd;
      @(posedge clk) disable iff (srst)
      txStart && txParityMode && !injParity |=> (^txShift) == 1'b1;
   endproperty
   a_parity_odd: assert property (p_parity_odd) else $error("tx parity not odd"); // RQ3 RQ12

   property p_parity_data;
      @(posedge clk) disable iff (srst)
      txStart && !txParityMode |=> txShift[31] == $past(txWord[31]);
   endproperty
   a_parity_data: assert property (p_parity_data) else $error("bit 32 data lost"); // RQ3

   property p_coding_bit;
      @(posedge clk) disable iff (srst)
      (txState == TX_BIT) && codingArm && bitNum == CODING_BIT |=> !txHi && !txLo;
   endproperty
   a_coding_bit: assert property (p_coding_bit) else $error("coding bit driven"); // RQ4

   property p_gap_inject;
      @(posedge clk) disable iff (srst)
      txStart && injGap && gapBits != 8'h00 |=> gapLeft == $past(gapBits) - 8'h01;
   endproperty
   a_gap_inject: assert property (p_gap_inject) else $error("gap not shortened"); // RQ4

   property p_rate_err;
      @(posedge clk) disable iff (srst)
      pulseStart && inWord && !rateOk |=> rxCoding;
   endproperty
   a_rate_err: assert property (p_rate_err) else $error("rate fault not flagged"); // RQ5

   property p_par_off;
      @(posedge clk) disable iff (srst)
      rxValid && !$past(rxParityMode) |-> !rxStatus[ST_PAR_ERR];
   endproperty
   a_par_off: assert property (p_par_off) else $error("parity flagged in data mode"); // RQ9

   property p_gap_range;
      @(posedge clk) disable iff (srst)
      rxValid |-> rxStatus[7:0] <= GAP_MAX_Q
         && rxStatus[ST_GAP_ERR] == (rxStatus[7:0] < GAP_MIN_Q);
   endproperty
   a_gap_range: assert property (p_gap_range) else $error("gap report wrong"); // RQ7 RQ8

   property p_count_err;
      @(posedge clk) disable iff (srst)
      rxValid |-> rxStatus[ST_CNT_ERR] == (rxBits != WORD_BITS);
   endproperty
   a_count_err: assert property (p_count_err) else $error("count flag wrong"); // RQ8

   property p_valid_pulse;
      @(posedge clk) disable iff (srst)
      rxValid |=> !rxValid;
   endproperty
   a_valid_pulse: assert property (p_valid_pulse) else $error("rx valid held"); // RQ10
endmodule : acw_codec

//--- acw_far_end.sv
// ****************************************
// Remote line equipment model
// ****************************************
module acw_far_end (
   input wire logic clk,
   input wire logic txHi,
   input wire logic txLo,
   output logic rxHi,
   output logic rxLo
);
   timeunit 1ns;
   timeprecision 1ns;
   int cyc = 0; // Cycle count
   int openCyc = 500; // Span since last heard bit start that opens a new heard word
   int rxLast = 0; // Start of last sent bit
   int txLast = -10000; // Start of last heard bit
   int txN = 0; // Bits heard in word
   int txMax = 0; // Widest bit spacing in word
   int txPw = 0; // Last pulse width
   logic [39:0] txBits = 40'h0; // Heard bits, first at 0
   logic actQ = 1'b0; // Line active last cycle
   initial begin
      rxHi = 1'b0;
      rxLo = 1'b0;
   end
   // Count on the falling edge, so it is steady at rising edges
   always @(negedge clk) cyc <= cyc + 1;
   // Listener: a bit at each rise out of null
   always @(posedge clk) begin
      actQ <= txHi | txLo;
      if ((txHi | txLo) && !actQ) begin
         if (cyc - txLast > openCyc) begin // Long null opens a word
            txN <= 1;
            txBits <= {39'h0, txHi};
            txMax <= 0;
         end else begin
            txBits[txN] <= txHi;
            txN <= txN + 1;
            if (cyc - txLast > txMax) begin
               txMax <= cyc - txLast;
            end
         end
         txLast <= cyc;
         txPw <= 1;
      end else if (txHi | txLo) begin
         txPw <= txPw + 1;
      end
   end
   // Talker: return to zero bits, first bit after gapCyc from last start
   task automatic sendWord(input logic [31:0] w, input int nb, per, gapCyc, codBit);
      logic b;
      do @(posedge clk); while (cyc < rxLast + gapCyc);
      for (int i = 0; i < nb; i++) begin
         b = (i < 32) ? w[i] : 1'b0;
         rxLast = cyc;
         rxHi <= b | (i == codBit); // Both lines high is a line fault
         rxLo <= ~b | (i == codBit);
         repeat (per / 2) @(posedge clk);
         rxHi <= 1'b0;
         rxLo <= 1'b0;
         repeat (per - per / 2) @(posedge clk);
      end
   endtask : sendWord
endmodule : acw_far_end

//--- acw_codec_tb.sv
// ****************************************
// Self-checking bench for the word codec
// ****************************************
module acw_codec_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import acw_pkg::*;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic speedHigh = 1'b1;
   logic [7:0] gapBits = 8'h00;
   logic txParityMode = 1'b0;
   logic injGap = 1'b0;
   acw_cnt_t injCount = ACW_CNT_NONE;
   logic injCoding = 1'b0;
   logic injParity = 1'b0;
   logic [31:0] txWord = 32'h0;
   logic txValid = 1'b0;
   logic rxParityMode = 1'b0;
   logic txReady, txHi, txLo, rxHi, rxLo, rxValid;
   logic [31:0] rxWord;
   logic [15:0] rxStatus;
   int errorCnt = 0; // Mismatches
   int nCompared = 0; // Comparisons
   always #25 clk = ~clk; // 20 MHz
   acw_codec dut (.clk(clk), .srst(srst), .speedHigh(speedHigh), .gapBits(gapBits),
      .txParityMode(txParityMode), .injGap(injGap), .injCount(injCount),
      .injCoding(injCoding), .injParity(injParity), .txWord(txWord), .txValid(txValid),
      .txReady(txReady), .txHi(txHi), .txLo(txLo), .rxParityMode(rxParityMode),
      .rxHi(rxHi), .rxLo(rxLo), .rxWord(rxWord), .rxStatus(rxStatus), .rxValid(rxValid));
   acw_far_end far (.clk(clk), .txHi(txHi), .txLo(txLo), .rxHi(rxHi), .rxLo(rxLo));
   // ****************************************
   // Helpers
   // ****************************************
   task automatic endSim();
      if (errorCnt == 0 && nCompared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : endSim
   task automatic chk(input logic [47:0] got, exp, input string m);
      nCompared++;
      if (got !== exp) begin
         errorCnt++;
         $display("[FAIL] %0t %s got %0h exp %0h", $time, m, got, exp);
      end
   endtask : chk
   task automatic near(input logic [15:0] got, input int exp, tol, input string m);
      nCompared++;
      if ($isunknown(got) || int'(got) < exp - tol || int'(got) > exp + tol) begin
         errorCnt++;
         $display("[FAIL] %0t %s got %0d exp %0d", $time, m, got, exp);
      end
   endtask : near
   // Word with bit 32 set for odd ones count
   function automatic logic [31:0] par(input logic [31:0] w);
      return {~^w[30:0], w[30:0]};
   endfunction : par
   // Send one word, time busy span, compare heard bits
   task automatic txRun(input logic [31:0] w, input logic pm, ip, icod, ig,
         input logic [7:0] g, input acw_cnt_t ic, input int nb,
         input logic [32:0] expBits, input logic cb, input int bt);
      int n;
      @(posedge clk);
      txWord <= w;
      txParityMode <= pm;
      injParity <= ip;
      injCoding <= icod;
      injGap <= ig;
      gapBits <= g;
      injCount <= ic;
      txValid <= 1'b1;
      @(posedge clk);
      txValid <= 1'b0;
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (txReady !== 1'b1 && n < 20000);
      if (n >= 20000) begin
         errorCnt++;
         $display("[FAIL] %0t tx never idle", $time);
         endSim();
      end
      near(16'(n), bt * BIT_HI_CYC, 4, "tx busy span");
      chk(48'(far.txN), 48'(nb), "tx bit count");
      if (cb) chk(48'(far.txBits[32:0]), 48'(expBits), "tx bits");
      repeat (400) @(posedge clk);
   endtask : txRun
   // Receive one word from the far end and compare report
   task automatic rxRun(input logic [31:0] w, input logic pm, input int nb, per, gap,
         cod, input logic [3:0] expErr, input int expGapQ);
      int n;
      @(posedge clk);
      rxParityMode <= pm;
      far.sendWord(w, nb, per, gap, cod);
      #1;
      n = 0;
      while (rxValid !== 1'b1 && n < 1000) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n >= 1000) begin
         errorCnt++;
         $display("[FAIL] %0t rx word never delivered", $time);
         endSim();
      end
      chk(48'(rxStatus[15:8]), 48'(expErr), "rx error flags");
      near(16'(rxStatus[7:0]), expGapQ, 1, "rx gap");
      if (nb == 32 && expErr == 4'h0) chk(48'(rxWord), 48'(w), "rx word");
   endtask : rxRun
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      int n;
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      #1;
      chk({txReady, txHi, txLo, rxValid}, 48'h8, "reset outputs");
      chk({rxWord, rxStatus}, 48'h0, "reset report");
      fork
         begin
            // Transmit side
            txRun(32'h3, 1, 0, 0, 0, 8'h03, ACW_CNT_NONE, 32, {1'b0, par(32'h3)}, 1, 35);
            near(16'(far.txPw), BIT_HI_CYC / 2, 1, "tx pulse width");
            txRun(32'h80000001, 0, 1, 0, 0, 8'h00, ACW_CNT_NONE, 32, 33'h080000001, 1, 32);
            txRun(32'h1, 1, 1, 0, 0, 8'h01, ACW_CNT_PLUS, 33, {1'b0, par(32'h1) ^ 32'h80000000},
               1, 34);
            txRun(32'h1, 1, 0, 0, 0, 8'h00, ACW_CNT_MINUS, 31, 33'h0, 0, 31);
            txRun(32'h5, 0, 0, 1, 1, 8'h05, ACW_CNT_NONE, 31, 33'h0, 0, 36);
            near(16'(far.txMax), 2 * BIT_HI_CYC, 1, "tx coding hole");
         end
         begin
            // Receive side
            rxRun(par(32'h12345678), 1, 32, BIT_HI_CYC, 2000, -1, 4'h0, 235);
            rxRun(par(32'h00FF0F0F), 1, 32, BIT_HI_CYC, 1200, -1, 4'h0, 20);
            rxRun(par(32'hA5) ^ 32'h80000000, 1, 32, BIT_HI_CYC, 700, -1, 4'h9, 10);
            rxRun(32'h80000001, 0, 32, BIT_HI_CYC, 1200, -1, 4'h0, 20);
            rxRun(par(32'h77), 1, 31, BIT_HI_CYC, 1200, -1, 4'h2, 20);
            rxRun(par(32'h77), 1, 32, BIT_HI_CYC, 1200, 5, 4'h4, 20);
            rxRun(par(32'h33), 1, 32, 190, 1200, -1, 4'h0, 20);
            rxRun(par(32'h33), 1, 32, 240, 1200, -1, 4'h4, 20);
            rxRun(par(32'h33), 1, 32, BIT_HI_CYC, 15000, -1, 4'h0, 235);
         end
      join
      // Low speed bit spacing, then abort by reset
      @(posedge clk);
      speedHigh <= 1'b0;
      far.openCyc = 4000; // Low speed bits stand far apart
      txValid <= 1'b1;
      @(posedge clk);
      txValid <= 1'b0;
      n = 0;
      while (far.txN != 2 && n < 5000) begin
         @(posedge clk);
         n++;
      end
      if (n >= 5000) begin
         errorCnt++;
         $display("[FAIL] %0t low speed bits never heard", $time);
         endSim();
      end
      near(16'(far.txMax), BIT_LO_CYC, 1, "low speed bit time");
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk({txReady, txHi, txLo}, 48'h4, "reset abort");
      endSim();
   end
endmodule : acw_codec_tb
